// >>> hdl/via_pkg.sv
// package of constants and carriers for the vectored interrupt arbiter
package via_pkg;
  // ****************************************************************
  // register map (wishbone, byte addresses)
  // ****************************************************************
  localparam logic [3:0] VIA_CTRL_OFS = 4'h0;
  localparam logic [3:0] VIA_IRQ_EN_OFS = 4'h4;
  localparam logic [3:0] VIA_IRQ_PND_OFS = 4'h8;
  localparam logic [3:0] VIA_STATUS_OFS = 4'hc;
  localparam int VIA_CTRL_GIE_BIT = 0;
  localparam int VIA_STAT_GIE_BIT = 0;
  localparam int VIA_STAT_ACTIVE_BIT = 1;
  localparam int VIA_STAT_VEC_LSB = 8;
  localparam logic VIA_GIE_RST = 1'b0;
  localparam logic [12:0] VIA_EN_RST = 13'h0000;
  // ****************************************************************
  // vectoring constants
  // ****************************************************************
  localparam int VIA_NSRC = 13;
  localparam logic [7:0] VIA_VEC_TRAP = 8'hfe;
  localparam logic [7:0] VIA_VEC_NMI = 8'hfc;
  localparam logic [7:0] VIA_VEC_EXT = 8'hfa;
  localparam logic [7:0] VIA_VEC_IDLE = 8'hf8;
  localparam logic [7:0] VIA_VEC_T1A = 8'hf6;
  localparam logic [7:0] VIA_VEC_T1B = 8'hf4;
  localparam logic [7:0] VIA_VEC_SERIAL = 8'hf2;
  localparam logic [7:0] VIA_VEC_RSV = 8'hf0;
  localparam logic [7:0] VIA_VEC_RX = 8'hee;
  localparam logic [7:0] VIA_VEC_TX = 8'hec;
  localparam logic [7:0] VIA_VEC_T2A = 8'hea;
  localparam logic [7:0] VIA_VEC_T2B = 8'he8;
  localparam logic [7:0] VIA_VEC_T3 = 8'he6;
  localparam logic [7:0] VIA_VEC_PORT = 8'he2;
  localparam logic [7:0] VIA_VEC_DEFAULT = 8'he0;
  localparam logic [14:0] VIA_ACK_PC = 15'h00ff;
  localparam logic [14:0] VIA_OVERPOP_PC = 15'h7fff;
  localparam logic [7:0] VIA_TRAP_OPCODE = 8'h00;
  localparam logic [7:0] VIA_STACK_LIMIT = 8'h6f;
  localparam int VIA_ACK_CYCLES = 7;
  typedef enum logic [1:0] {
    VIA_PC_HOLD, VIA_PC_LOAD, VIA_PC_LOW
  } via_pc_op_t;
  // pc command to the sequencer
  typedef struct packed {
    via_pc_op_t op;
    logic [14:0] pc;
    logic push;
    logic [14:0] push_addr;
  } via_pc_cmd_t;
  // cpu decode strobes toward the arbiter
  typedef struct packed {
    logic instr_start;
    logic vector_select_instr;
    logic clr_trap;
    logic return_from_irq_instr;
    logic fetch;
    logic [7:0] opcode;
    logic [14:0] fetch_addr;
  } via_cpu_t;
endpackage : via_pkg

// >>> hdl/via_arbiter.sv
// vectored interrupt arbiter with hidden software-trap pending flag
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module via_arbiter
  import via_pkg::*;
#(
  parameter int PROG_SIZE = 32768
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu sequencer
  input wire via_cpu_t cpu_i,
  input wire logic [14:0] pc_i,
  input wire logic [14:0] stack_pc_i,
  input wire logic [7:0] sp_i,
  input wire logic pop_i,
  output via_pc_cmd_t pc_cmd_o,
  output logic busy_o,
  output logic [7:0] ir_o,
  // program memory
  input wire logic [7:0] pmem_dat_i,
  output logic pmem_rd_o,
  output logic [14:0] pmem_adr_o,
  // maskable pending bits, bit 12 = nmi reserved, bit 0 = port edge
  input wire logic [VIA_NSRC-1:0] irq_pnd_i
);
  initial begin
    if (PROG_SIZE < 1 || PROG_SIZE > 32768) begin
      $error("PROG_SIZE out of range");
    end
    // the ranking chain below is written out for exactly 13 sources
    if (VIA_NSRC != 13) begin
      $error("ranking chain needs 13 sources");
    end
    // the acknowledge counter is three bits wide
    if (VIA_ACK_CYCLES < 1 || VIA_ACK_CYCLES > 8) begin
      $error("acknowledge count does not fit its counter");
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  typedef enum {
    S_IDLE, S_ACK, S_VEC_HI, S_VEC_LO, S_VEC_CAP, S_VEC_LD
  } via_state_t;
  via_state_t state;
  logic global_irq_enable;
  logic [VIA_NSRC-1:0] irq_en;
  logic trap_pending_flag; // hidden: not in the map
  logic [2:0] ack_cnt;
  logic [14:0] vec_adr;
  logic [6:0] vec_hi;
  logic [7:0] vec_byte;
  logic in_trap_svc;

  // ****************************************************************
  // arbitration
  // ****************************************************************
  wire [VIA_NSRC-1:0] active = irq_en & irq_pnd_i;
  logic [7:0] arb_byte;
  // trap first, then bit 12 down to bit 0; the chain is the ranking
  always_comb begin
    if (trap_pending_flag) begin
      arb_byte = VIA_VEC_TRAP;
    end else if (active[12]) begin
      arb_byte = VIA_VEC_NMI;
    end else if (active[11]) begin
      arb_byte = VIA_VEC_EXT;
    end else if (active[10]) begin
      arb_byte = VIA_VEC_IDLE;
    end else if (active[9]) begin
      arb_byte = VIA_VEC_T1A;
    end else if (active[8]) begin
      arb_byte = VIA_VEC_T1B;
    end else if (active[7]) begin
      arb_byte = VIA_VEC_SERIAL;
    end else if (active[6]) begin
      arb_byte = VIA_VEC_RSV;
    end else if (active[5]) begin
      arb_byte = VIA_VEC_RX;
    end else if (active[4]) begin
      arb_byte = VIA_VEC_TX;
    end else if (active[3]) begin
      arb_byte = VIA_VEC_T2A;
    end else if (active[2]) begin
      arb_byte = VIA_VEC_T2B;
    end else if (active[1]) begin
      // both third-timer events share one pending bit here
      arb_byte = VIA_VEC_T3;
    end else if (active[0]) begin
      arb_byte = VIA_VEC_PORT;
    end else begin
      arb_byte = VIA_VEC_DEFAULT;
    end
  end

  // ****************************************************************
  // fetch path
  // ****************************************************************
  wire unprog = 32'(cpu_i.fetch_addr) >= PROG_SIZE;
  wire overpop_loc = cpu_i.fetch_addr == VIA_OVERPOP_PC;
  // unprogrammed space and the overpop location read as zero
  wire [7:0] fetched = (unprog || overpop_loc) ? VIA_TRAP_OPCODE
                                               : pmem_dat_i;
  wire trap_fetch = cpu_i.fetch && fetched == VIA_TRAP_OPCODE;
  wire overpop = pop_i && sp_i > VIA_STACK_LIMIT;
  // pending trap inhibits maskable irqs; a trap routine ignores them
  wire mask_take = cpu_i.instr_start && global_irq_enable && |active[11:0]
                   && !trap_pending_flag && !in_trap_svc
                   && state == S_IDLE;
  wire vis_go = cpu_i.vector_select_instr && cpu_i.instr_start && state == S_IDLE;
  // table block: next block if vis sits at last byte of its block
  wire [6:0] blk = (pc_i[7:0] == 8'hff) ? 7'(pc_i[14:8] + 7'h01)
                                        : pc_i[14:8];
  wire ack_last = state == S_ACK && ack_cnt == 3'(VIA_ACK_CYCLES - 1);
  wire ret_go = cpu_i.return_from_irq_instr && state == S_IDLE;
  wire next_busy = state != S_IDLE || mask_take || vis_go;
  wire next_pmem_rd = state == S_VEC_HI || state == S_VEC_LO;

  // ****************************************************************
  // control
  // ****************************************************************
  via_pc_cmd_t next_cmd;
  always_comb begin
    next_cmd.op = VIA_PC_HOLD;
    next_cmd.pc = pc_i;
    next_cmd.push = 1'b0;
    next_cmd.push_addr = pc_i;
    if (trap_fetch && state == S_IDLE) begin
      // push the trap opcode's own address: a plain return re-traps
      next_cmd.op = VIA_PC_LOAD;
      next_cmd.pc = VIA_ACK_PC;
      next_cmd.push = 1'b1;
      next_cmd.push_addr = cpu_i.fetch_addr;
    end else if (overpop) begin
      next_cmd.op = VIA_PC_LOAD;
      next_cmd.pc = VIA_OVERPOP_PC;
    end else if (ack_last) begin
      next_cmd.op = VIA_PC_LOAD;
      next_cmd.pc = VIA_ACK_PC;
      next_cmd.push = 1'b1;
      next_cmd.push_addr = pc_i;
    end else if (vis_go) begin
      // only the low byte moves; the block follows the vis address
      next_cmd.op = VIA_PC_LOW;
      next_cmd.pc = {blk, arb_byte};
    end else if (state == S_VEC_LD) begin
      next_cmd.op = VIA_PC_LOAD;
      next_cmd.pc = {vec_hi, vec_byte};
    end else if (ret_go) begin
      next_cmd.op = VIA_PC_LOAD;
      next_cmd.pc = stack_pc_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      ack_cnt <= 3'h0;
      vec_adr <= 15'h0000;
      vec_hi <= 7'h00;
      vec_byte <= 8'h00;
      in_trap_svc <= 1'b0;
    end else begin
      vec_byte <= pmem_dat_i;
      case (state)
        S_IDLE: begin
          ack_cnt <= 3'h0;
          if (mask_take) begin
            state <= S_ACK;
          end else if (vis_go) begin
            vec_adr <= {blk, arb_byte};
            state <= S_VEC_HI;
          end
        end
        S_ACK: begin
          ack_cnt <= ack_cnt + 3'h1;
          if (ack_cnt == 3'(VIA_ACK_CYCLES - 1)) begin
            state <= S_IDLE;
          end
        end
        S_VEC_HI: begin
          vec_adr <= vec_adr + 15'h0001;
          state <= S_VEC_LO;
        end
        S_VEC_LO: begin
          state <= S_VEC_CAP;
        end
        S_VEC_CAP: begin
          // memory answers a cycle after the address: high byte is here
          vec_hi <= vec_byte[6:0];
          state <= S_VEC_LD;
        end
        S_VEC_LD: begin
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (trap_fetch) begin
        in_trap_svc <= 1'b1;
      end else if (cpu_i.clr_trap) begin
        in_trap_svc <= 1'b0;
      end
    end
  end

  // set wins over the clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_pending_flag <= 1'b0;
    end else if (trap_fetch) begin
      trap_pending_flag <= 1'b1;
    end else if (cpu_i.clr_trap) begin
      trap_pending_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs, one short register block each
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_cmd_o <= '{op: VIA_PC_HOLD, pc: 15'h0000, push: 1'b0,
                    push_addr: 15'h0000};
    end else begin
      pc_cmd_o <= next_cmd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= next_busy;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_o <= 8'h00;
    end else if (cpu_i.fetch) begin
      ir_o <= fetched;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmem_rd_o <= 1'b0;
    end else begin
      pmem_rd_o <= next_pmem_rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmem_adr_o <= 15'h0000;
    end else begin
      pmem_adr_o <= vec_adr;
    end
  end

  // ****************************************************************
  // wishbone slave; trap flag deliberately absent from the map
  // ****************************************************************
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = wb_req && wb_we_i;
  wire hit_ctrl = wb_adr_i == VIA_CTRL_OFS;
  wire hit_en = wb_adr_i == VIA_IRQ_EN_OFS;
  wire hit_pnd = wb_adr_i == VIA_IRQ_PND_OFS;
  wire hit_stat = wb_adr_i == VIA_STATUS_OFS;
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, global_irq_enable}
    : hit_en ? {19'h0, irq_en}
    : hit_pnd ? {19'h0, irq_pnd_i}
    : hit_stat ? {16'h0, arb_byte, 6'h00, |active, global_irq_enable}
    : 32'h0;

  wire wr_ctrl = wr && hit_ctrl && wb_sel_i[0];
  wire wr_en_lo = wr && hit_en && wb_sel_i[0];
  wire wr_en_hi = wr && hit_en && wb_sel_i[1];

  // ack is a single-cycle pulse: a held strobe is answered again every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= rd_mux;
    end
  end

  // hardware take and return outrank a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable <= VIA_GIE_RST;
    end else if (mask_take) begin
      global_irq_enable <= 1'b0;
    end else if (ret_go) begin
      global_irq_enable <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable <= wb_dat_i[VIA_CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en[7:0] <= VIA_EN_RST[7:0];
    end else if (wr_en_lo) begin
      irq_en[7:0] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en[12:8] <= VIA_EN_RST[12:8];
    end else if (wr_en_hi) begin
      irq_en[12:8] <= wb_dat_i[12:8];
    end
  end
endmodule : via_arbiter

// >>> dv/via_arbiter_properties.sv
// concurrent checks on the vectored interrupt arbiter ports
`timescale 1ns/10ps
module via_chk
  import via_pkg::*;
#(
  parameter int PROG_SIZE = 32768
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire via_cpu_t cpu_i,
  input wire logic [14:0] pc_i,
  input wire logic [7:0] sp_i,
  input wire logic pop_i,
  input wire via_pc_cmd_t pc_cmd_o,
  input wire logic busy_o,
  input wire logic [7:0] ir_o,
  input wire logic [7:0] pmem_dat_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic go = cpu_i.instr_start && cpu_i.vector_select_instr && !busy_o;
  wire logic low = pc_cmd_o.op == VIA_PC_LOW;
  wire logic load = pc_cmd_o.op == VIA_PC_LOAD;
  wire logic ftz = cpu_i.fetch && pmem_dat_i == 8'h00;
  wire logic [6:0] blk = pc_i[14:8] + 7'(pc_i[7:0] == 8'hff);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  vis_low_a: assert property (go |=> low)
    else $error("no vector byte");
  vis_block_a: assert property (go |=> pc_cmd_o.pc[14:8] == $past(blk))
    else $error("vector block wrong");
  vis_even_a: assert property (low |-> pc_cmd_o.pc[7:5] == 3'b111
    && !pc_cmd_o.pc[0]) else $error("vector byte odd");
  vis_load_a: assert property (low |-> ##[1:8] load)
    else $error("vector not loaded");
  trap_take_a: assert property (ftz |=> load && pc_cmd_o.push
    && pc_cmd_o.push_addr == $past(cpu_i.fetch_addr)) else $error("trap");
  unprog_a: assert property (cpu_i.fetch && cpu_i.fetch_addr >= PROG_SIZE
    |=> ir_o == 8'h00) else $error("unprogrammed byte not zero");
  overpop_a: assert property (pop_i && sp_i > VIA_STACK_LIMIT
    |-> ##[1:3] load && pc_cmd_o.pc == VIA_OVERPOP_PC) else $error("overpop");
  cover property (go);
  cover property (ftz);
  cover property (pop_i && sp_i > VIA_STACK_LIMIT);
endmodule : via_chk

// >>> dv/via_pmem_model.sv
// program memory model facing the arbiter
`timescale 1ns/10ps
module via_pmem_model (
  input wire logic rd_i,
  input wire logic [14:0] adr_i,
  output logic [7:0] dat_o
);
  // vector high byte first: the word at an even byte is its own address + 1
  wire logic [7:0] w = adr_i[0] ? adr_i[7:0] : {1'b0, adr_i[14:8]};
  // released bus shows the inverse so stale data cannot pass
  assign dat_o = rd_i ? w : ~w;
endmodule : via_pmem_model

// >>> dv/vectored_interrupt_arbiter_tb_top.sv
// testbench for the vectored interrupt arbiter
`timescale 1ns/10ps
module vectored_interrupt_arbiter_tb_top;
  import via_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pop = 0;
  logic ack, busy, prd;
  logic [3:0] adr = '0;
  logic [31:0] wd = '0, rd, q;
  logic [14:0] pc = '0, padr;
  logic [7:0] sp = '0, ir, pdat;
  logic [12:0] pnd = '0;
  via_cpu_t cpu = '0;
  via_pc_cmd_t cmd;
  int bad_count = 0, cmp_count = 0, n;
  always #5 clk_i = ~clk_i;
  via_arbiter #(.PROG_SIZE(4096)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .cpu_i(cpu), .pc_i(pc),
    .stack_pc_i(pc), .sp_i(sp), .pop_i(pop), .pc_cmd_o(cmd), .busy_o(busy),
    .ir_o(ir), .pmem_dat_i(pdat), .pmem_rd_o(prd), .pmem_adr_o(padr),
    .irq_pnd_i(pnd));
  via_pmem_model pm (.rd_i(prd | cpu.fetch),
    .adr_i(cpu.fetch ? cpu.fetch_addr : padr), .dat_o(pdat));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // flags: start, vector select, clear trap, return, fetch
  task automatic go(input logic [4:0] f, input logic [14:0] a);
    @(posedge clk_i);
    cpu <= {f, 8'h00, a};
    @(posedge clk_i);
    cpu <= '0;
  endtask : go
  task automatic want(input via_pc_op_t o, input logic [14:0] p);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd.op !== o && n < 20);
    chk(cmd.pc, p);
  endtask : want
  task automatic vector_select_instr(input logic [14:0] p, input logic [7:0] b);
    logic [6:0] bl;
    bl = p[14:8] + 7'(p[7:0] == 8'hff);
    pc <= p;
    go(5'b11000, 0);
    want(VIA_PC_LOW, {bl, b});
    chk(busy, 1);
    want(VIA_PC_LOAD, {bl, b | 8'h01});
  endtask : vector_select_instr
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 4'h4, 32'h1fff);
    wb(0, 4'h4, 0);
    chk(q, 32'h1fff);
    wb(0, 4'h2, 0);
    chk(q, 0);
    for (int i = 0; i < 13; i++) begin
      pnd <= 13'h1fff >> (12 - i);
      wb(0, 4'hc, 0);
      chk(q[15:8], i == 0 ? 8'he2 : 8'he0 + 8'(2 * (i + 2)));
    end
    wb(1, 4'h4, 0);
    wb(0, 4'hc, 0);
    chk(q[15:8], VIA_VEC_DEFAULT);
    wb(1, 4'h4, 32'h0800);
    vector_select_instr(15'h0123, VIA_VEC_EXT);
    vector_select_instr(15'h01ff, VIA_VEC_EXT);
    wb(1, 4'h0, 1);
    go(5'b00001, 15'h0050);
    want(VIA_PC_LOAD, VIA_ACK_PC);
    chk(cmd.push_addr, 15'h0050);
    wb(0, 4'hc, 0);
    chk(q[0], 1);
    go(5'b10000, 0);
    repeat (12) begin
      @(posedge clk_i);
      chk(cmd.op, VIA_PC_HOLD);
    end
    vector_select_instr(15'h0100, VIA_VEC_TRAP);
    go(5'b00100, 0);
    wb(0, 4'hc, 0);
    chk(q[15:8], VIA_VEC_EXT);
    pc <= 15'h0234;
    go(5'b10000, 0);
    want(VIA_PC_LOAD, VIA_ACK_PC);
    chk(cmd.push_addr, 15'h0234);
    chk(n >= VIA_ACK_CYCLES, 1);
    wb(0, 4'hc, 0);
    chk(q[0], 0);
    go(5'b00010, 0);
    wb(0, 4'hc, 0);
    chk(q[0], 1);
    wb(1, 4'h0, 0);
    go(5'b00001, 15'h0051);
    @(posedge clk_i);
    chk({cmd.op, ir}, {VIA_PC_HOLD, 8'h51});
    go(5'b00001, 15'h7fff);
    want(VIA_PC_LOAD, VIA_ACK_PC);
    chk(ir, 0);
    @(posedge clk_i);
    {sp, pop} <= {8'h7f, 1'b1};
    @(posedge clk_i);
    pop <= 0;
    want(VIA_PC_LOAD, VIA_OVERPOP_PC);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'hc, 0);
    chk(q[15:8], VIA_VEC_DEFAULT);
    tally_and_finish();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : vectored_interrupt_arbiter_tb_top
bind via_arbiter via_chk #(.PROG_SIZE(PROG_SIZE)) u_chk (.*);
